// File: rtl/sar_readout_consts.vh
`ifndef SAR_READOUT_CONSTS_VH
`define SAR_READOUT_CONSTS_VH

`define RES_BITS        16
`define LEAD_EDGES      4'h5
`define CNT_W           6
`define CODE_POS_FULL   16'h7fff
`define CODE_NEG_FULL   16'h8000
`define CODE_ZERO       16'h0000
`define ST_ACQUIRE      2'h0
`define ST_CONVERT      2'h1
`define ST_SLEEP        2'h2

`endif

// File: rtl/sar_engine.v
`timescale 1ns/1ps
`include "sar_readout_consts.vh"
// successive-approximation of a digital stand-in for the held sample
module sar_engine #(
	parameter WIDTH = `RES_BITS
) (
	input  wire             clk,
	input  wire             srst,
	input  wire             start,
	input  wire [WIDTH:0]   sample,
	output reg  [WIDTH-1:0] result,
	output reg              done
);
	// sample is signed WIDTH+1 bits, so overrange can be represented
	reg  [WIDTH-1:0] trial_reg;
	reg  [WIDTH-1:0] bit_reg;
	reg              busy_reg;
	wire signed [WIDTH:0] s = sample;
	reg  signed [WIDTH:0] held_reg;
	wire [WIDTH-1:0] cand = trial_reg | bit_reg;

	always @(posedge clk) begin
		if (srst) begin
			trial_reg <= {WIDTH{1'b0}};
			bit_reg   <= {WIDTH{1'b0}};
			busy_reg  <= 1'b0;
			held_reg  <= {(WIDTH+1){1'b0}};
			result    <= `CODE_ZERO;
			done      <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start) begin
				// offset-binary search on held input, msb first
				held_reg  <= s;
				trial_reg <= {WIDTH{1'b0}};
				bit_reg   <= {1'b1, {(WIDTH-1){1'b0}}};
				busy_reg  <= 1'b1;
			end else if (busy_reg) begin
				if ($signed({1'b0, cand}) - $signed({1'b0, 1'b1, {(WIDTH-1){1'b0}}})
						<= held_reg)
					trial_reg <= cand;
				bit_reg <= bit_reg >> 1;
				if (bit_reg[0]) begin
					busy_reg <= 1'b0;
					done     <= 1'b1;
					// offset to two's complement, clamps naturally at ends
					result   <= ((($signed({1'b0, cand}) - $signed({1'b0, 1'b1,
						{(WIDTH-1){1'b0}}})) <= held_reg) ? cand : trial_reg)
						^ {1'b1, {(WIDTH-1){1'b0}}};
				end
			end
		end
	end
endmodule // sar_engine

// File: rtl/sar_adc_serial_readout.v
`timescale 1ns/1ps
`include "sar_readout_consts.vh"
module sar_adc_serial_readout #(
	parameter WIDTH = `RES_BITS
) (
	input  wire             clk,
	input  wire             srst,
	input  wire             select_n,
	input  wire             shift_clock,
	input  wire [WIDTH:0]   analog_sample,
	output reg              data_out,
	output reg              data_oe_n,
	output wire             low_power,
	output wire             tracking
);
	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	// both pins idle high, so the edge detectors start high and no
	// false fall follows reset
	reg [1:0] sel_sync_reg;
	reg [1:0] sck_sync_reg;
	reg       sel_prev_reg;
	reg       sck_prev_reg;

	always @(posedge clk) begin
		if (srst) begin
			sel_sync_reg <= 2'h3;
			sck_sync_reg <= 2'h3;
			sel_prev_reg <= 1'b1;
			sck_prev_reg <= 1'b1;
		end else begin
			sel_sync_reg <= {sel_sync_reg[0], select_n};
			sck_sync_reg <= {sck_sync_reg[0], shift_clock};
			sel_prev_reg <= sel_sync_reg[1];
			sck_prev_reg <= sck_sync_reg[1];
		end
	end

	wire sel_fall = sel_prev_reg & ~sel_sync_reg[1];
	wire sel_high = sel_sync_reg[1];
	// falls seen while deselected belong to another device's frame
	wire sck_fall = sck_prev_reg & ~sck_sync_reg[1] & ~sel_high;

	// ----------------------------------------
	// conversion control
	// ----------------------------------------
	localparam [1:0] ACQUIRE = `ST_ACQUIRE;
	localparam [1:0] CONVERT = `ST_CONVERT;
	localparam [1:0] SLEEP   = `ST_SLEEP;

	reg  [1:0]       state_reg;
	reg  [1:0]       state_next;
	wire [WIDTH-1:0] conv_result;
	wire             conv_done;

	sar_engine #(
		.WIDTH (WIDTH)
	) u_sar_engine (
		.clk    (clk),
		.srst   (srst),
		.start  (sel_fall),
		.sample (analog_sample),
		.result (conv_result),
		.done   (conv_done)
	);

	always @* begin
		state_next = state_reg;
		case (state_reg)
			ACQUIRE: begin
				if (sel_fall)
					state_next = CONVERT;
			end
			CONVERT: begin
				// a select that drops again mid-conversion restarts the engine
				if (conv_done)
					state_next = SLEEP;
			end
			SLEEP: begin
				if (sel_fall)
					state_next = CONVERT;
			end
			default: begin
				state_next = ACQUIRE;
			end
		endcase
	end

	always @(posedge clk) begin
		if (srst)
			state_reg <= ACQUIRE;
		else
			state_reg <= state_next;
	end

	// converter core powered down outside the conversion phase;
	// the input is tracked over the same interval
	assign low_power = (state_reg != CONVERT);
	assign tracking  = (state_reg != CONVERT);

	// ----------------------------------------
	// serial frame sequencer
	// ----------------------------------------
	// lead: falls counted with the output released
	// word: one result bit per counted fall
	// tail: word exhausted, line driven low on each further fall until select rises
	localparam [1:0] LINK_LEAD = 2'h0;
	localparam [1:0] LINK_WORD = 2'h1;
	localparam [1:0] LINK_TAIL = 2'h2;

	reg  [1:0]        link_reg;
	reg  [1:0]        link_next;
	reg  [`CNT_W-1:0] edge_cnt_reg;
	reg  [`CNT_W-1:0] edge_cnt_next;
	reg  [WIDTH-1:0]  left_reg;
	reg  [WIDTH-1:0]  left_next;
	reg  [WIDTH-1:0]  shift_reg;
	wire [WIDTH-1:0]  shift_next;
	wire [WIDTH:0]    shift_chain;
	reg               loaded_reg;
	reg               shift_bit;
	wire              load_word;
	wire              lead_done;
	wire              word_last;

	// a result landing while deselected belongs to an abandoned frame
	assign load_word   = conv_done & ~sel_high;
	assign lead_done   = (edge_cnt_reg == {2'h0, `LEAD_EDGES} - 6'h1);
	assign word_last   = ~|left_reg[WIDTH-2:0];
	assign shift_chain = {shift_reg, 1'b0};

	always @* begin
		link_next     = link_reg;
		edge_cnt_next = edge_cnt_reg;
		left_next     = left_reg;
		shift_bit     = 1'b0;
		case (link_reg)
			LINK_LEAD: begin
				if (sck_fall) begin
					edge_cnt_next = edge_cnt_reg + {{(`CNT_W-1){1'b0}}, 1'b1};
					if (lead_done) begin
						link_next = LINK_WORD;
						left_next = {WIDTH{1'b1}};
					end
				end
			end
			LINK_WORD: begin
				if (sck_fall) begin
					shift_bit = 1'b1;
					left_next = {left_reg[WIDTH-2:0], 1'b0};
					if (word_last)
						link_next = LINK_TAIL;
				end
			end
			LINK_TAIL: begin
				// extra falls only shift out zeros
				link_next = LINK_TAIL;
			end
			default: begin
				link_next = LINK_LEAD;
			end
		endcase
		// deselect abandons the frame from any point
		if (sel_high) begin
			link_next     = LINK_LEAD;
			edge_cnt_next = {`CNT_W{1'b0}};
		end
	end

	// ----------------------------------------
	// result shifter
	// ----------------------------------------
	// load beats shift: a word arriving late is not shifted past
	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_shift
			assign shift_next[gi] = load_word ? conv_result[gi] :
				(shift_bit ? shift_chain[gi] : shift_reg[gi]);
		end
	endgenerate

	always @(posedge clk) begin
		if (srst) begin
			link_reg     <= LINK_LEAD;
			edge_cnt_reg <= {`CNT_W{1'b0}};
			left_reg     <= {WIDTH{1'b0}};
			shift_reg    <= {WIDTH{1'b0}};
			loaded_reg   <= 1'b0;
		end else begin
			link_reg     <= link_next;
			edge_cnt_reg <= edge_cnt_next;
			left_reg     <= left_next;
			shift_reg    <= shift_next;
			if (sel_high)
				loaded_reg <= 1'b0;
			else if (load_word)
				loaded_reg <= 1'b1;
		end
	end

	// ----------------------------------------
	// output pins
	// ----------------------------------------
	// a host clocking before the result is ready reads zeros, never
	// the word of the previous frame
	always @(posedge clk) begin
		if (srst) begin
			data_out  <= 1'b0;
			data_oe_n <= 1'b1;
		end else if (sel_high) begin
			data_out  <= 1'b0;
			data_oe_n <= 1'b1;
		end else if (sck_fall) begin
			case (link_reg)
				LINK_LEAD: begin
					if (lead_done) begin
						data_oe_n <= 1'b0;
						data_out  <= 1'b0;
					end
				end
				LINK_WORD: begin
					// held until the next fall, so valid on both edges
					data_out <= loaded_reg ? shift_reg[WIDTH-1] : 1'b0;
				end
				default: begin
					data_out <= 1'b0;
				end
			endcase
		end
	end
endmodule // sar_adc_serial_readout

// File: testbench/sar_readout_props.sv
`timescale 1ns/1ps
module sar_readout_props #(
	parameter WIDTH = 16
) (
	input wire           clk,
	input wire           srst,
	input wire           select_n,
	input wire           shift_clock,
	input wire [WIDTH:0] analog_sample,
	input wire           data_out,
	input wire           data_oe_n,
	input wire           low_power,
	input wire           tracking
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	chk_oe_release: assert property ($rose(select_n) |-> ##[1:6] data_oe_n)
		else $error("oe late");
	chk_idle_quiet: assert property (select_n [*7] |-> data_oe_n)
		else $error("idle drive");
	chk_lead_low: assert property ($fell(data_oe_n) |-> !data_out)
		else $error("lead high");
	chk_no_early: assert property ($fell(select_n) |-> data_oe_n [*8])
		else $error("early drive");
	chk_conv_start: assert property ($fell(select_n) |-> ##[1:6] !low_power)
		else $error("no start");
	chk_conv_end: assert property ($fell(low_power) |-> ##[12:24] low_power)
		else $error("no sleep");
	chk_track_hold: assert property (select_n && tracking |=> tracking)
		else $error("track lost");
	chk_track_drop: assert property ($fell(select_n) |-> ##[1:6] !tracking)
		else $error("track held");
	chk_reset_safe: assert property (disable iff (1'b0) srst |=> data_oe_n && low_power)
		else $error("rst");
	cover property ($fell(data_oe_n));
	cover property ($fell(low_power));
	cover property ($rose(data_oe_n));
endmodule // sar_readout_props

// File: testbench/host_model.sv
`timescale 1ns/1ps
module host_model (
	input  wire        clk,
	input  wire        sdo,
	output reg         select_n,
	output reg         shift_clock,
	output reg  [16:0] word,
	output reg         word_v
);
	integer i;
	initial begin
		select_n = 1'b1;
		shift_clock = 1'b1;
		word = 17'h00000;
		word_v = 1'b0;
	end
	// clock idles high between frames
	task frame;
		begin
			@(negedge clk) select_n = 1'b0;
			repeat (24) @(negedge clk);
			for (i = 0; i < 21; i = i + 1) begin
				shift_clock = 1'b0;
				repeat (4) @(negedge clk);
				shift_clock = 1'b1;
				if (i > 3) word = {word[15:0], sdo};
				repeat (4) @(negedge clk);
			end
			select_n = 1'b1;
			word_v = 1'b1;
			@(negedge clk) word_v = 1'b0;
		end
	endtask
endmodule // host_model

// File: testbench/sar_adc_serial_readout_tb.sv
`timescale 1ns/1ps
module sar_adc_serial_readout_tb;
	reg         clk, srst;
	reg  [16:0] smp;
	reg  [16:0] q[$];
	wire        sel_n, sclk, dout, oe_n, lp, trk, wv;
	wire [16:0] word;
	// released line: inverse of last level, no stale value
	wire        sdo = oe_n ? ~dout : dout;
	integer     n_errors = 0, checks_done = 0, seed = 32'h0baffadd, k;
	sar_adc_serial_readout u_sar_adc_serial_readout (.clk(clk), .srst(srst),
		.select_n(sel_n), .shift_clock(sclk), .analog_sample(smp), .data_out(dout),
		.data_oe_n(oe_n), .low_power(lp), .tracking(trk));
	host_model u_host_model (.clk(clk), .sdo(sdo), .select_n(sel_n),
		.shift_clock(sclk), .word(word), .word_v(wv));
	task cmp(input [16:0] g, input [16:0] e);
		begin
			checks_done = checks_done + 1;
			if (g !== e) begin
				n_errors = n_errors + 1;
				$display("BAD %0t %h %h", $time, g, e);
			end
		end
	endtask
	task cmp_flags(input [2:0] g, input [2:0] e);
		begin
			checks_done = checks_done + 1;
			if (g !== e) begin
				n_errors = n_errors + 1;
				$display("BAD %0t %h %h", $time, g, e);
			end
		end
	endtask
	task end_sim;
		begin
			if (n_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
			else $display("MISMATCHES SEEN");
			$finish;
		end
	endtask
	task conv(input [16:0] s);
		begin
			smp = s;
			q.push_back({1'b0, (!s[16] && s[15]) ? 16'h7fff : (s[16] && !s[15]) ? 16'h8000 : s[15:0]});
			fork
				u_host_model.frame;
				begin
					repeat (12) @(negedge clk);
					smp = ~s;
					cmp_flags({oe_n, lp, trk}, 3'h4);
				end
			join
			repeat (8) @(negedge clk);
			cmp_flags({oe_n, lp, trk}, 3'h7);
		end
	endtask
	always @(posedge clk) if (wv === 1'b1) cmp(word, q.pop_front());
	initial begin clk = 1'b0; forever #12.5 clk = ~clk; end
	initial begin #200000; n_errors = n_errors + 1; end_sim; end
	initial begin
		srst = 1'b1;
		smp = 17'h00000;
		repeat (4) @(negedge clk);
		srst = 1'b0;
		repeat (4) @(negedge clk);
		conv(17'h00000);
		conv(17'h07fff);
		conv(17'h08000);
		conv(17'h18000);
		conv(17'h17fff);
		conv(17'h1ffff);
		repeat (6) begin k = $random(seed); conv(k[16:0]); end
		end_sim;
	end
endmodule // sar_adc_serial_readout_tb
bind sar_adc_serial_readout sar_readout_props #(.WIDTH(WIDTH)) u_props (.clk(clk), .srst(srst),
	.select_n(select_n), .shift_clock(shift_clock), .analog_sample(analog_sample),
	.data_out(data_out), .data_oe_n(data_oe_n), .low_power(low_power), .tracking(tracking));
